// *** motion_fault_trap_defines.svh ***
`ifndef MOTION_FAULT_TRAP_DEFINES_SVH
`define MOTION_FAULT_TRAP_DEFINES_SVH
// ==========================================================
// widths
`define MFT_STATUS_W 16
`define MFT_SPEED_W 16
`define MFT_CODE_W 7
`define MFT_LINE_W 16
`define MFT_CC_W 8
`define MFT_CNT_W 8
`define MFT_ADDR_W 16
`define MFT_UNIT_W 7
// ==========================================================
// reset values and codes
`define MFT_MASK_RESET 16'h0100
`define MFT_CODE_MIN 7'h01
`define MFT_CODE_MAX 7'h52
`define MFT_CC_TABLE 8'h01
`define MFT_CC_VR 8'h02
`define MFT_THREE 8'h03
// ==========================================================
// host register byte addresses (word aligned)
`define MFT_REG_CTRL 6'h00
`define MFT_REG_XCMD 6'h04
`define MFT_REG_XADDR 6'h08
`define MFT_REG_STAT 6'h0c
`define MFT_REG_UNIT 6'h10
`define MFT_REG_CLR 6'h14
`define MFT_REG_ERR0 6'h18
`define MFT_REG_MIS0 6'h24
`define MFT_REG_XCH0 6'h30
// ==========================================================
// field positions
`define MFT_XCMD_CC 7:0
`define MFT_XCMD_CNT 15:8
`define MFT_XCMD_THREE 16
`define MFT_XCMD_WR 17
`define MFT_XCMD_TBL 18
`endif

// *** motion_fault_trap_pkg.sv ***
`include "motion_fault_trap_defines.svh"
package motion_fault_trap_pkg;
  // ==========================================================
  // shared types
  typedef logic [`MFT_STATUS_W-1:0] status_word_t; // one axis status word
  typedef logic [`MFT_SPEED_W-1:0] speed_word_t; // signed speed reference
  typedef enum logic [1:0] {run_idle, run_active, run_stopped, run_in_handler} run_state_t;
endpackage : motion_fault_trap_pkg

// *** fault_link_if.sv ***
`include "motion_fault_trap_defines.svh"
interface fault_link_if;
  logic xfer_req; // host block transfer request, pulse
  logic xfer_write; // 1 write, 0 read
  logic xfer_three_word; // three-word format
  logic xfer_table_sel; // 1 table, 0 user variables
  logic [`MFT_CC_W-1:0] xfer_code; // control code
  logic [`MFT_CNT_W-1:0] xfer_count; // word count
  logic [`MFT_ADDR_W-1:0] xfer_addr; // start address
  logic xfer_done; // answer, pulse
  logic xfer_err; // transfer error, pulse
  logic restart_toggle; // host restart bit, level
  logic [`MFT_UNIT_W-1:0] unit_num; // installed unit number
  logic refresh_beat; // toggles each refresh
  logic unit_error; // device error summary
  modport dev (input xfer_req, xfer_write, xfer_three_word, xfer_table_sel, xfer_code,
    xfer_count, xfer_addr, restart_toggle,
    output xfer_done, xfer_err, unit_num, refresh_beat, unit_error);
  modport host (output xfer_req, xfer_write, xfer_three_word, xfer_table_sel, xfer_code,
    xfer_count, xfer_addr, restart_toggle,
    input xfer_done, xfer_err, unit_num, refresh_beat, unit_error);
endinterface : fault_link_if

// *** motion_fault_trap.sv ***
// Chosen here: the register addresses and the Avalon-MM slave port.
`include "motion_fault_trap_defines.svh"
module motion_fault_trap #(
  parameter int NUM_AXES = 4,
  parameter int AXIS_W = 2,
  parameter int TABLE_WORDS = 16000,
  parameter int VR_WORDS = 1024,
  parameter int PEND_CAP = 4,
  parameter int REFRESH_CYCLES = 64,
  parameter logic [`MFT_UNIT_W-1:0] UNIT_NUMBER = 7'h00
) (
  input wire logic ref_clk,
  input wire logic rst,
  fault_link_if.dev link,
  input wire motion_fault_trap_pkg::status_word_t axis_status_bits [NUM_AXES],
  input wire motion_fault_trap_pkg::speed_word_t speed_cmd [NUM_AXES],
  output motion_fault_trap_pkg::speed_word_t speed_ref [NUM_AXES],
  output logic drive_enable_relay,
  input wire logic mask_wr,
  input wire motion_fault_trap_pkg::status_word_t mask_wdata,
  output motion_fault_trap_pkg::status_word_t axis_fault_mask,
  input wire logic fault_clear,
  output logic motion_fault,
  output logic [AXIS_W-1:0] fault_axis,
  input wire logic interp_fault,
  input wire logic [`MFT_CODE_W-1:0] interp_code,
  input wire logic [`MFT_LINE_W-1:0] interp_line,
  input wire logic error_trap_handler,
  output logic program_stop,
  output logic handler_branch,
  output logic [`MFT_CODE_W-1:0] run_error,
  output logic [`MFT_LINE_W-1:0] error_line,
  input wire logic program_host_req,
  input wire logic pend_retire,
  output logic program_host_err,
  output logic restart_pulse
);
  // ==========================================================
  // restart detect
  logic restart_seen; // last sampled host restart bit
  logic restart_go; // one-cycle soft restart
  logic [$clog2(PEND_CAP+1)-1:0] pend_cnt; // pending transfers
  logic [$clog2(REFRESH_CYCLES)-1:0] beat_cnt; // refresh divider
  logic [NUM_AXES-1:0] hit; // per-axis match
  logic [AXIS_W-1:0] first_hit; // lowest matching axis

  assign restart_go = link.restart_toggle != restart_seen;

  // host bit sampled on the same clock, no synchroniser needed
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      restart_seen <= 1'b0;
      restart_pulse <= 1'b0;
    end else begin
      restart_seen <= link.restart_toggle;
      restart_pulse <= restart_go;
    end
  end

  // ==========================================================
  // fault compare
  // lowest index wins so reports are repeatable
  function automatic logic [AXIS_W-1:0] lowest_set(input logic [NUM_AXES-1:0] v);
    lowest_set = '0;
    for (int i = NUM_AXES - 1; i >= 0; i--) begin
      if (v[i]) begin
        lowest_set = AXIS_W'(i);
      end
    end
  endfunction : lowest_set

  genvar g;
  generate
    for (g = 0; g < NUM_AXES; g++) begin : g_axis
      assign hit[g] = |(axis_status_bits[g] & axis_fault_mask);
      // speed reference follows command only while relay is on
      always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
          speed_ref[g] <= '0;
        end else if (!drive_enable_relay || restart_go) begin
          speed_ref[g] <= '0;
        end else begin
          speed_ref[g] <= speed_cmd[g];
        end
      end
    end
  endgenerate

  assign first_hit = lowest_set(hit);

  // ==========================================================
  // mask register
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      axis_fault_mask <= `MFT_MASK_RESET;
    end else if (restart_go) begin
      axis_fault_mask <= `MFT_MASK_RESET;
    end else if (mask_wr) begin
      axis_fault_mask <= mask_wdata;
    end
  end

  // ==========================================================
  // fault latch; a new match beats a clear in the same cycle
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      motion_fault <= 1'b0;
      drive_enable_relay <= 1'b0;
      fault_axis <= '0;
    end else if (restart_go) begin
      motion_fault <= 1'b0;
      drive_enable_relay <= 1'b0;
      fault_axis <= '0;
    end else if (|hit) begin
      motion_fault <= 1'b1;
      drive_enable_relay <= 1'b0;
      if (!motion_fault || fault_clear) begin
        fault_axis <= first_hit;
      end
    end else if (fault_clear) begin
      // relay comes back only through an explicit clear
      motion_fault <= 1'b0;
      drive_enable_relay <= 1'b1;
      fault_axis <= '0;
    end
  end

  // ==========================================================
  // interpreter fault capture
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      run_error <= '0;
      error_line <= '0;
      program_stop <= 1'b0;
      handler_branch <= 1'b0;
    end else if (restart_go) begin
      run_error <= '0;
      error_line <= '0;
      program_stop <= 1'b0;
      handler_branch <= 1'b0;
    end else begin
      program_stop <= interp_fault && !error_trap_handler;
      handler_branch <= interp_fault && error_trap_handler;
      if (interp_fault) begin
        error_line <= interp_line;
        // out-of-range causes are clamped to the highest code
        if (interp_code < `MFT_CODE_MIN || interp_code > `MFT_CODE_MAX) begin
          run_error <= `MFT_CODE_MAX;
        end else begin
          run_error <= interp_code;
        end
      end
    end
  end

  // ==========================================================
  // block transfer checks
  function automatic logic xfer_bad(
    input logic [`MFT_CC_W-1:0] cc,
    input logic three,
    input logic tbl,
    input logic [`MFT_CNT_W-1:0] cnt,
    input logic [`MFT_ADDR_W-1:0] adr
  );
    logic [`MFT_ADDR_W:0] span;
    logic [`MFT_ADDR_W:0] lim;
    span = {1'b0, adr} + {{(`MFT_ADDR_W+1-`MFT_CNT_W){1'b0}}, cnt};
    lim = tbl ? (`MFT_ADDR_W+1)'(TABLE_WORDS) : (`MFT_ADDR_W+1)'(VR_WORDS);
    xfer_bad = (cc != `MFT_CC_TABLE && cc != `MFT_CC_VR)
      || (three && (cnt % `MFT_THREE) != '0)
      || (span > lim);
  endfunction : xfer_bad

  logic host_bad; // request fails its checks
  logic host_take; // request would occupy a slot
  logic pend_full; // no free slot
  logic prog_take; // program request occupies a slot
  assign host_bad = xfer_bad(link.xfer_code, link.xfer_three_word, link.xfer_table_sel,
    link.xfer_count, link.xfer_addr);
  assign pend_full = pend_cnt >= ($bits(pend_cnt))'(PEND_CAP);
  assign host_take = link.xfer_req && !host_bad && !pend_full;
  // host request has priority over a program request for the last slot
  assign prog_take = program_host_req && !pend_full && !(host_take
    && pend_cnt == ($bits(pend_cnt))'(PEND_CAP - 1));

  // answer one cycle after the request
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      link.xfer_done <= 1'b0;
      link.xfer_err <= 1'b0;
      program_host_err <= 1'b0;
    end else begin
      link.xfer_done <= link.xfer_req && !restart_go;
      link.xfer_err <= !restart_go && ((link.xfer_req && (host_bad || pend_full))
        || (program_host_req && !prog_take));
      program_host_err <= program_host_req && !prog_take && !restart_go;
    end
  end

  // occupancy of the pending transfer slots
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pend_cnt <= '0;
    end else if (restart_go) begin
      pend_cnt <= '0;
    end else begin
      pend_cnt <= pend_cnt + ($bits(pend_cnt))'(host_take) + ($bits(pend_cnt))'(prog_take)
        - ($bits(pend_cnt))'(pend_retire && pend_cnt != '0);
    end
  end

  // ==========================================================
  // cyclic refresh heartbeat and status to host
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      beat_cnt <= '0;
      link.refresh_beat <= 1'b0;
      link.unit_error <= 1'b0;
      link.unit_num <= '0;
    end else begin
      link.unit_num <= UNIT_NUMBER;
      link.unit_error <= motion_fault;
      if (beat_cnt == ($bits(beat_cnt))'(REFRESH_CYCLES - 1)) begin
        beat_cnt <= '0;
        link.refresh_beat <= !link.refresh_beat;
      end else begin
        beat_cnt <= beat_cnt + 1'b1;
      end
    end
  end
endmodule : motion_fault_trap

// *** host_fault_monitor.sv ***
`include "motion_fault_trap_defines.svh"
module host_fault_monitor #(
  parameter int NUM_UNITS = 96,
  parameter int BEAT_TIMEOUT = 1024
) (
  input wire logic ref_clk,
  input wire logic rst,
  fault_link_if.host link,
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest
);
  // ==========================================================
  // state
  logic [NUM_UNITS-1:0] unit_err; // per-unit error bits
  logic [NUM_UNITS-1:0] unit_mis; // per-unit mismatch bits
  logic [NUM_UNITS-1:0] unit_xch; // per-unit exchange failure bits
  logic xfer_err_flag; // transfer error flag
  logic dup_flag; // duplicate unit number
  logic xfer_busy; // awaiting device answer
  logic [`MFT_UNIT_W-1:0] reg_unit; // registered unit number
  logic [`MFT_UNIT_W-1:0] prev_unit; // unit number last cycle
  logic beat_seen; // last heartbeat level
  logic [$clog2(BEAT_TIMEOUT+1)-1:0] beat_age; // cycles since heartbeat
  logic beat_lost; // refresh has stopped
  logic wr_go; // write takes effect
  logic in_range; // unit number is addressable
  logic [NUM_UNITS-1:0] unit_bit; // one-hot unit position

  assign wr_go = avs_write && !avs_waitrequest;
  assign in_range = link.unit_num < `MFT_UNIT_W'(NUM_UNITS);
  assign unit_bit = in_range ? (NUM_UNITS'(1) << link.unit_num) : '0;
  assign beat_lost = beat_age >= ($bits(beat_age))'(BEAT_TIMEOUT);

  // pick one 32-bit slice of a unit array
  function automatic logic [31:0] slice(input logic [NUM_UNITS-1:0] v, input logic [1:0] k);
    logic [127:0] wide;
    wide = 128'(v);
    slice = wide[k*32 +: 32];
  endfunction : slice

  // ==========================================================
  // avalon slave: one wait cycle, then answer
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= '0;
    end else if ((avs_read || avs_write) && avs_waitrequest) begin
      avs_waitrequest <= 1'b0;
      case (avs_address)
        `MFT_REG_CTRL: avs_readdata <= {31'h0000_0000, link.restart_toggle};
        `MFT_REG_XADDR: avs_readdata <= {16'h0000, link.xfer_addr};
        `MFT_REG_STAT: avs_readdata <= {26'h000_0000, dup_flag, xfer_err_flag, xfer_busy,
          |unit_xch, |unit_mis, |unit_err};
        `MFT_REG_UNIT: avs_readdata <= {25'h000_0000, reg_unit};
        `MFT_REG_ERR0, `MFT_REG_ERR0 + 6'h04, `MFT_REG_ERR0 + 6'h08:
          avs_readdata <= slice(unit_err, 2'(avs_address - `MFT_REG_ERR0 >> 2));
        `MFT_REG_MIS0, `MFT_REG_MIS0 + 6'h04, `MFT_REG_MIS0 + 6'h08:
          avs_readdata <= slice(unit_mis, 2'(avs_address - `MFT_REG_MIS0 >> 2));
        `MFT_REG_XCH0, `MFT_REG_XCH0 + 6'h04, `MFT_REG_XCH0 + 6'h08:
          avs_readdata <= slice(unit_xch, 2'(avs_address - `MFT_REG_XCH0 >> 2));
        default: avs_readdata <= '0; // unmapped reads zero
      endcase
    end else begin
      avs_waitrequest <= 1'b1;
    end
  end

  // ==========================================================
  // restart bit, registered unit, transfer launch
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      link.restart_toggle <= 1'b0;
      reg_unit <= '0;
      link.xfer_req <= 1'b0;
      link.xfer_write <= 1'b0;
      link.xfer_three_word <= 1'b0;
      link.xfer_table_sel <= 1'b0;
      link.xfer_code <= '0;
      link.xfer_count <= '0;
      link.xfer_addr <= '0;
      xfer_busy <= 1'b0;
    end else begin
      link.xfer_req <= 1'b0;
      if (link.xfer_done) begin
        xfer_busy <= 1'b0;
      end
      if (wr_go && avs_address == `MFT_REG_CTRL && avs_writedata[0]) begin
        link.restart_toggle <= !link.restart_toggle;
      end
      if (wr_go && avs_address == `MFT_REG_UNIT) begin
        reg_unit <= avs_writedata[`MFT_UNIT_W-1:0];
      end
      if (wr_go && avs_address == `MFT_REG_XADDR) begin
        link.xfer_addr <= avs_writedata[`MFT_ADDR_W-1:0];
      end
      // a command while busy is dropped
      if (wr_go && avs_address == `MFT_REG_XCMD && !xfer_busy) begin
        link.xfer_req <= 1'b1;
        xfer_busy <= 1'b1;
        link.xfer_code <= avs_writedata[`MFT_XCMD_CC];
        link.xfer_count <= avs_writedata[`MFT_XCMD_CNT];
        link.xfer_three_word <= avs_writedata[`MFT_XCMD_THREE];
        link.xfer_write <= avs_writedata[`MFT_XCMD_WR];
        link.xfer_table_sel <= avs_writedata[`MFT_XCMD_TBL];
      end
    end
  end

  // ==========================================================
  // refresh watchdog
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      beat_seen <= 1'b0;
      beat_age <= '0;
      prev_unit <= '0;
    end else begin
      beat_seen <= link.refresh_beat;
      prev_unit <= link.unit_num;
      if (link.refresh_beat != beat_seen) begin
        beat_age <= '0;
      end else if (!beat_lost) begin
        beat_age <= beat_age + 1'b1;
      end
    end
  end

  // ==========================================================
  // error flags; a new event beats a clear in the same cycle
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      unit_err <= '0;
      unit_mis <= '0;
      unit_xch <= '0;
      xfer_err_flag <= 1'b0;
      dup_flag <= 1'b0;
    end else begin
      if (wr_go && avs_address == `MFT_REG_CLR) begin
        unit_err <= (link.unit_error || beat_lost) ? unit_bit : '0;
        unit_mis <= (link.unit_num != reg_unit) ? unit_bit : '0;
        unit_xch <= beat_lost ? unit_bit : '0;
        xfer_err_flag <= link.xfer_err;
        dup_flag <= link.unit_num != prev_unit;
      end else begin
        unit_err <= unit_err | ((link.unit_error || beat_lost) ? unit_bit : '0);
        unit_mis <= unit_mis | ((link.unit_num != reg_unit) ? unit_bit : '0);
        unit_xch <= unit_xch | (beat_lost ? unit_bit : '0);
        xfer_err_flag <= xfer_err_flag | link.xfer_err;
        // a unit number that changes under us means two units answer
        dup_flag <= dup_flag | (link.unit_num != prev_unit);
      end
    end
  end
endmodule : host_fault_monitor

// *** motion_fault_trap_sva.sv ***
`include "motion_fault_trap_defines.svh"
// ==========================================================
// link checker between the two ends
module motion_fault_trap_sva #(
  parameter int TABLE_WORDS = 16000,
  parameter int VR_WORDS = 1024,
  parameter int REFRESH_CYCLES = 64
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic xfer_req,
  input wire logic xfer_three_word,
  input wire logic xfer_table_sel,
  input wire logic [`MFT_CC_W-1:0] xfer_code,
  input wire logic [`MFT_CNT_W-1:0] xfer_count,
  input wire logic [`MFT_ADDR_W-1:0] xfer_addr,
  input wire logic xfer_done,
  input wire logic xfer_err,
  input wire logic restart_toggle,
  input wire logic [`MFT_UNIT_W-1:0] unit_num,
  input wire logic refresh_beat,
  input wire logic unit_error
);
  logic [15:0] beat_age; // cycles since the beat last moved
  logic beat_prev; // beat level one cycle ago
  logic code_bad; // control code outside the supported pair
  int span; // start address plus length
  assign code_bad = (xfer_code != `MFT_CC_TABLE) && (xfer_code != `MFT_CC_VR);
  assign span = int'(xfer_addr) + int'(xfer_count);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  // ==========================================================
  // heartbeat age; a soft restart leaves the divider running, but allow two periods
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      beat_age <= 16'h0000;
      beat_prev <= 1'b0;
    end else begin
      beat_prev <= refresh_beat;
      // plain compare, so no clock has to be inferred here
      if (refresh_beat != beat_prev) begin
        beat_age <= 16'h0000;
      end else begin
        beat_age <= beat_age + 16'h0001;
      end
    end
  end
  // ==========================================================
  // assertions
  a_bad_code_err: assert property (xfer_req && code_bad |=> xfer_done && xfer_err)
    else $error("unsupported control code not flagged");
  a_three_count_err: assert property (
    xfer_req && xfer_three_word && (xfer_count % 3 != 0) |=> xfer_done && xfer_err)
    else $error("three-word count not flagged");
  a_table_range_err: assert property (
    xfer_req && xfer_table_sel && span > TABLE_WORDS |=> xfer_err)
    else $error("table range overrun not flagged");
  a_vr_range_err: assert property (xfer_req && !xfer_table_sel && span > VR_WORDS |=> xfer_err)
    else $error("variable range overrun not flagged");
  a_req_gets_done: assert property (xfer_req |=> xfer_done)
    else $error("transfer not answered in one cycle");
  a_done_single: assert property (xfer_done |=> !xfer_done)
    else $error("done longer than one cycle");
  a_restart_clears: assert property ($changed(restart_toggle) |-> ##[1:3] !unit_error)
    else $error("restart left the unit error up");
  a_unit_steady: assert property (!$past(rst) |-> $stable(unit_num))
    else $error("unit number moved");
  a_beat_alive: assert property (beat_age <= 16'(2 * REFRESH_CYCLES + 2))
    else $error("refresh beat stalled");
endmodule : motion_fault_trap_sva

// *** motion_fault_trap_test.sv ***
`include "motion_fault_trap_defines.svh"
// ==========================================================
// both ends joined, user sides driven by the bench
module motion_fault_trap_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk, rst; // clock and async reset
  motion_fault_trap_pkg::status_word_t st [4]; // axis status words
  motion_fault_trap_pkg::speed_word_t cmd [4], spd [4]; // speed in and out
  motion_fault_trap_pkg::status_word_t mwd, mask; // mask write and readback
  logic relay, mask_wr, fclr, mfault, ifault, trap, pstop, hbr, preq, pret, perr, rpulse;
  logic [1:0] fax; // faulting axis
  logic [6:0] icode, rerr; // interpreter code in and out
  logic [15:0] iline, eline; // interpreter line in and out
  logic [5:0] adr; // avalon side
  logic rd, wr, wreq;
  logic [31:0] wdat, rdat, got;
  logic [31:0] xcmd [6]; // transfer table: command word, address, expected error
  logic [15:0] xadr [6];
  logic xerr [6];
  int bad_count = 0, n_checks = 0;
  fault_link_if link ();
  motion_fault_trap #(.REFRESH_CYCLES(8)) u_motion_fault_trap (.ref_clk(ref_clk), .rst(rst),
    .link(link), .axis_status_bits(st), .speed_cmd(cmd), .speed_ref(spd),
    .drive_enable_relay(relay), .mask_wr(mask_wr), .mask_wdata(mwd), .axis_fault_mask(mask),
    .fault_clear(fclr), .motion_fault(mfault), .fault_axis(fax), .interp_fault(ifault),
    .interp_code(icode), .interp_line(iline), .error_trap_handler(trap), .program_stop(pstop),
    .handler_branch(hbr), .run_error(rerr), .error_line(eline), .program_host_req(preq),
    .pend_retire(pret), .program_host_err(perr), .restart_pulse(rpulse));
  host_fault_monitor #(.BEAT_TIMEOUT(32)) u_host_fault_monitor (.ref_clk(ref_clk), .rst(rst),
    .link(link), .avs_address(adr), .avs_read(rd), .avs_write(wr), .avs_writedata(wdat),
    .avs_readdata(rdat), .avs_waitrequest(wreq));
  motion_fault_trap_sva #(.REFRESH_CYCLES(8)) u_motion_fault_trap_sva (.ref_clk(ref_clk),
    .rst(rst), .xfer_req(link.xfer_req), .xfer_three_word(link.xfer_three_word),
    .xfer_table_sel(link.xfer_table_sel), .xfer_code(link.xfer_code),
    .xfer_count(link.xfer_count), .xfer_addr(link.xfer_addr), .xfer_done(link.xfer_done),
    .xfer_err(link.xfer_err), .restart_toggle(link.restart_toggle), .unit_num(link.unit_num),
    .refresh_beat(link.refresh_beat), .unit_error(link.unit_error));
  // ==========================================================
  // clock, 4 ns period
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  // ==========================================================
  // shared tasks
  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string what);
    n_checks++;
    if (g !== e) begin
      bad_count++;
      $display("Error at %0t: %s got %h expected %h", $time, what, g, e);
    end
  endtask : chk
  // one avalon access; entered and left on a rising edge
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
    int n;
    n = 0;
    adr <= a;
    wdat <= d;
    wr <= w;
    rd <= !w;
    do begin
      @(posedge ref_clk);
      n++;
    end while (wreq !== 1'b0 && n < 50);
    if (n >= 50) chk(32'h0000_0000, 32'h0000_0001, "bus wait");
    got = rdat; // taken at the accepting edge
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge ref_clk);
  endtask : bus
  // wait until the host end has no transfer in flight
  task automatic wait_idle();
    for (int i = 0; i < 20; i++) begin
      bus(1'b0, `MFT_REG_STAT, 32'h0000_0000);
      if (got[3] === 1'b0) break;
    end
    chk(32'(got[3]), 32'h0000_0000, "host idle");
  endtask : wait_idle
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : give_verdict
  // watchdog well above the expected run length
  initial begin
    #200000;
    bad_count++;
    give_verdict();
  end
  // ==========================================================
  // main sequence
  initial begin
    rst = 1'b1;
    foreach (st[i]) st[i] = 16'h0000;
    foreach (cmd[i]) cmd[i] = 16'h1234;
    {mask_wr, fclr, ifault, trap, preq, pret, rd, wr} = 8'h00;
    mwd = 16'h0000;
    icode = 7'h00;
    iline = 16'h0000;
    adr = 6'h00;
    wdat = 32'h0000_0000;
    xcmd = '{32'h0004_0105, 32'h0005_0401, 32'h0005_0301, 32'h0004_0201, 32'h0002_0102,
      32'h0000_0202};
    xadr = '{16'h0000, 16'h0000, 16'h0000, 16'h3e7f, 16'h03ff, 16'h03ff};
    xerr = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1};
    repeat (10) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    #1 chk(32'(mask), 32'h0000_0100, "mask reset");
    @(posedge ref_clk);
    fclr <= 1'b1;
    @(posedge ref_clk);
    fclr <= 1'b0;
    @(posedge ref_clk);
    #1 chk(32'(relay), 32'h0000_0001, "relay on");
    chk(32'(spd[1]), 32'h0000_1234, "speed passes");
    // two axes hit together, lowest one is kept
    @(posedge ref_clk);
    st[2] <= 16'h0100;
    st[3] <= 16'h0100;
    @(posedge ref_clk);
    #1 chk(32'(mfault), 32'h0000_0001, "fault flag");
    chk(32'(relay), 32'h0000_0000, "relay off");
    chk(32'(fax), 32'h0000_0002, "lowest axis");
    @(posedge ref_clk);
    st[1] <= 16'h0100;
    #1 foreach (spd[i]) chk(32'(spd[i]), 32'h0000_0000, "speed zero");
    repeat (3) @(posedge ref_clk);
    #1 chk(32'(fax), 32'h0000_0002, "first axis kept");
    @(posedge ref_clk);
    bus(1'b0, `MFT_REG_ERR0, 32'h0000_0000);
    chk(32'(got[0]), 32'h0000_0001, "unit error bit");
    bus(1'b0, `MFT_REG_STAT, 32'h0000_0000);
    chk(32'(got[0]), 32'h0000_0001, "error summary");
    chk(32'(got[5]), 32'h0000_0000, "no duplicate unit");
    bus(1'b0, 6'h3c, 32'h0000_0000);
    chk(got, 32'h0000_0000, "unmapped read");
    // register a different unit number, then restore it
    bus(1'b1, `MFT_REG_UNIT, 32'h0000_0001);
    bus(1'b0, `MFT_REG_MIS0, 32'h0000_0000);
    chk(32'(got[0]), 32'h0000_0001, "unit mismatch bit");
    bus(1'b0, `MFT_REG_XCH0, 32'h0000_0000);
    chk(got, 32'h0000_0000, "no exchange failure");
    bus(1'b1, `MFT_REG_UNIT, 32'h0000_0000);
    foreach (st[i]) st[i] <= 16'h0000;
    fclr <= 1'b1;
    mask_wr <= 1'b1;
    mwd <= 16'h0001;
    @(posedge ref_clk);
    {fclr, mask_wr} <= 2'b00;
    st[0] <= 16'h0100;
    repeat (2) @(posedge ref_clk);
    #1 chk(32'(mfault), 32'h0000_0000, "masked bit ignored");
    @(posedge ref_clk);
    st[0] <= 16'h0101;
    @(posedge ref_clk);
    #1 chk(32'(mfault), 32'h0000_0001, "new mask bit hits");
    chk(32'(fax), 32'h0000_0000, "axis zero");
    @(posedge ref_clk);
    st[0] <= 16'h0000;
    fclr <= 1'b1;
    @(posedge ref_clk);
    fclr <= 1'b0;
    // interpreter fault: stop, then branch to the trap handler
    for (int k = 0; k < 2; k++) begin
      trap <= k[0];
      icode <= k[0] ? 7'h52 : 7'h09;
      iline <= 16'h0100 + 16'(k);
      ifault <= 1'b1;
      @(posedge ref_clk);
      ifault <= 1'b0;
      #1 chk(32'(pstop), 32'(!k[0]), "program stop");
      chk(32'(hbr), 32'(k[0]), "handler branch");
      chk(32'(rerr), k[0] ? 32'h0000_0052 : 32'h0000_0009, "run error code");
      chk(32'(eline), 32'h0000_0100 + 32'(k), "error line");
      @(posedge ref_clk);
    end
    // host block transfers, one flag check each
    for (int k = 0; k < 6; k++) begin
      bus(1'b1, `MFT_REG_CLR, 32'h0000_0001);
      bus(1'b1, `MFT_REG_XADDR, 32'(xadr[k]));
      bus(1'b1, `MFT_REG_XCMD, xcmd[k]);
      wait_idle();
      chk(32'(got[4]), 32'(xerr[k]), "transfer error flag");
    end
    // soft restart, then fill the pending slots
    bus(1'b1, `MFT_REG_CTRL, 32'h0000_0001);
    // the pulse stands one cycle only, so look at it mid-cycle
    for (int i = 0; i < 10 && rpulse !== 1'b1; i++) @(negedge ref_clk);
    chk(32'(rpulse), 32'h0000_0001, "restart pulse");
    chk(32'(mask), 32'h0000_0100, "mask after restart");
    chk(32'(relay), 32'h0000_0000, "relay after restart");
    @(posedge ref_clk);
    for (int k = 0; k < 5; k++) begin
      preq <= 1'b1;
      @(posedge ref_clk);
      preq <= 1'b0;
      #1 chk(32'(perr), 32'(k == 4), "program slot overflow");
      @(posedge ref_clk);
    end
    bus(1'b1, `MFT_REG_CLR, 32'h0000_0001);
    bus(1'b1, `MFT_REG_XCMD, xcmd[2]);
    wait_idle();
    chk(32'(got[4]), 32'h0000_0001, "host overflow");
    pret <= 1'b1;
    @(posedge ref_clk);
    pret <= 1'b0;
    preq <= 1'b1;
    @(posedge ref_clk);
    preq <= 1'b0;
    #1 chk(32'(perr), 32'h0000_0000, "slot freed");
    @(posedge ref_clk);
    give_verdict();
  end
endmodule : motion_fault_trap_test
